// ===== bench/rcl_config_loader_chk.sv
`timescale 1ns/1ps
module rcl_config_loader_chk
  import rcl_pkg::*;
#(parameter int CODE_KB = CODE_KB_DEFAULT)(
  // watched ports
  input logic        REF_CLK,
  input logic        NRST,
  input logic        PRG_RD,
  input logic [14:0] PRG_ADDR,
  input logic [7:0]  CODE_RD_DATA,
  input logic [14:0] CODE_RD_ADDR,
  input logic [7:0]  PRG_RD_DATA,
  input logic        PRG_RD_VALID,
  input logic        PRG_RD_REFUSED,
  input logic        CFG_READY,
  input logic        SINGLE_RATE_CLOCKING,
  input logic        OSC_8MHZ,
  input logic        OSC_16MHZ,
  input logic        OSC_32MHZ,
  input logic        OSC_CFG_BAD,
  input logic [1:0]  SECURITY_LEVEL,
  input logic [7:0]  REG_ADDR,
  input logic        REG_RD,
  input logic [7:0]  REG_RDATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  sequence s_open;
    PRG_RD && SECURITY_LEVEL == 2'h1 && CFG_READY;
  endsequence
  sequence s_fit;
    int'(PRG_ADDR) < CODE_KB * 1024;
  endsequence
  AST_SRC: assert property (SINGLE_RATE_CLOCKING)
    else $error("single rate clocking off");
  AST_OSC: assert property (CFG_READY |->
    $onehot({OSC_8MHZ, OSC_16MHZ, OSC_32MHZ, OSC_CFG_BAD}))
    else $error("oscillator decode not one hot");
  AST_LVL: assert property (SECURITY_LEVEL inside {2'h1, 2'h3})
    else $error("bad security level");
  AST_ANS: assert property (PRG_RD |=> PRG_RD_VALID != PRG_RD_REFUSED)
    else $error("read answer not exactly one");
  AST_IDLE: assert property (!PRG_RD |=> !PRG_RD_VALID && !PRG_RD_REFUSED)
    else $error("answer without request");
  AST_LOCK: assert property (PRG_RD &&
    (SECURITY_LEVEL == 2'h3 || !CFG_READY) |=> PRG_RD_REFUSED)
    else $error("protected read not refused");
  AST_DATA: assert property (s_open ##0 s_fit |=>
    PRG_RD_VALID && PRG_RD_DATA == $past(CODE_RD_DATA))
    else $error("open read wrong");
  AST_ADDR: assert property (CODE_RD_ADDR == PRG_ADDR)
    else $error("code address mismatch");
  AST_RSV: assert property (REG_RD && REG_ADDR == CFG_BYTE_OFFSET |=>
    (REG_RDATA & ~CFG_USED_MASK) == 8'h00)
    else $error("reserved bits set");
  AST_RDZ: assert property (PRG_RD_REFUSED |-> PRG_RD_DATA == 8'h00)
    else $error("refused read carries data");
endmodule
bind rcl_config_loader rcl_config_loader_chk #(.CODE_KB(CODE_KB)) u_chk (.*);

// ===== bench/rcl_rom_model.sv
`timescale 1ns/1ps
// neighbouring bytes differ, so a wrong address shows up as wrong data
module rcl_rom_model (
  // code array port
  input  wire logic [14:0] ADDR,
  output logic [7:0]       DATA
);
  assign DATA = ADDR[7:0] ^ {1'b0, ADDR[14:8]};
endmodule

// ===== bench/test_rom_config_byte_and_lock.sv
`timescale 1ns/1ps
module test_rom_config_byte_and_lock;
  import rcl_pkg::*;
  localparam int KB = 16;
  logic        clk = 1'b0, nrst = 1'b0, p_rd = 1'b0, r_wr = 1'b0;
  logic        r_rd = 1'b0, vld, rfs, rdy, src, o8, o16, o32, bad;
  logic [7:0]  nv = 8'h33, r_a = 8'h00, r_wd = 8'h00, rom, p_d, r_d;
  logic [14:0] p_a = 15'h0000, c_a;
  logic [1:0]  lvl;
  logic [15:0] rnd = 16'h0003;
  int          miscompares = 0, n_tests = 0, cycles = 0;
  int          exp_q[$];
  always #5 clk = ~clk;
  rcl_config_loader #(.CODE_KB(KB)) u_rcl_config_loader (.REF_CLK(clk),
    .NRST(nrst), .NV_CFG_BYTE(nv), .PRG_RD(p_rd), .PRG_ADDR(p_a),
    .CODE_RD_DATA(rom), .CODE_RD_ADDR(c_a), .PRG_RD_DATA(p_d),
    .PRG_RD_VALID(vld), .PRG_RD_REFUSED(rfs), .CFG_READY(rdy),
    .SINGLE_RATE_CLOCKING(src), .OSC_8MHZ(o8), .OSC_16MHZ(o16),
    .OSC_32MHZ(o32), .OSC_CFG_BAD(bad), .SECURITY_LEVEL(lvl),
    .REG_ADDR(r_a), .REG_WDATA(r_wd), .REG_WR(r_wr), .REG_RD(r_rd),
    .REG_RDATA(r_d));
  rcl_rom_model u_rcl_rom_model (.ADDR(c_a), .DATA(rom));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hung handshake ends the run here
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    r_rd <= 1'b1;
    r_a <= a;
    @(posedge clk);
    r_rd <= 1'b0;
    #1 chk(r_d, e);
  endtask
  task automatic prg(input logic [14:0] a, input logic ok);
    @(posedge clk);
    p_rd <= 1'b1;
    p_a <= a;
    exp_q.push_back(ok ? int'(a[7:0] ^ {1'b0, a[14:8]}) : 0);
    @(posedge clk);
    p_rd <= 1'b0;
    #1 chk({6'h0, vld, rfs}, {6'h0, ok, !ok});
    chk(p_d, 8'(exp_q.pop_front()));
  endtask
  initial begin
    logic [7:0] cfg [4] = '{8'hF3, 8'hE1, 8'h13, 8'hD2};
    logic [7:0] c;
    logic [1:0] el;
    int         a;
    foreach (cfg[i]) begin
      c = cfg[i];
      el = (c[1:0] == 2'b11) ? 2'h1 : 2'h3;
      @(posedge clk);
      nrst <= 1'b0;
      nv <= c;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      prg(15'h0000, 1'b0);
      repeat (6) @(posedge clk);
      #1 chk({2'h0, rdy, src, o8, o16, o32, bad}, {4'h3, c[5:4] == 2'b01,
        c[5:4] == 2'b10, c[5:4] == 2'b11, 1'b0});
      chk({6'h0, lvl}, {6'h0, el});
      @(posedge clk);
      r_wr <= 1'b1;
      r_wd <= rnd[7:0];
      r_a <= CFG_BYTE_OFFSET;
      @(posedge clk);
      r_wr <= 1'b0;
      reg_chk(CFG_BYTE_OFFSET, c & CFG_USED_MASK);
      reg_chk(CODE_SIZE_OFFSET, 8'(KB));
      reg_chk(STATUS_OFFSET, {4'h0, el == 2'h3, el, 1'b1});
      reg_chk(8'h00, 8'h00);
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        a = (k == 0) ? KB * 1024 - 1 : (k == 1) ? KB * 1024 : rnd[13:0];
        prg(15'(a), el == 2'h1 && k != 1);
      end
    end
    conclude();
  end
endmodule

// ===== design/rcl_config_loader.sv
// Notes on behaviour
// - code array of 16 to 32 KB, separate one-byte configuration array
// - start-up options and security level come from the stored byte
// - start single-rate with default oscillator unless byte says otherwise
// - bits 5:4 select oscillator range 32, 16 or 8 MHz
// - both lock bits unprogrammed: level 1, programmer may read ROM
// - upper lock programmed, lower not: level 3, programmer reads refused
// - lock bits at 1:0; bits 7, 6, 3, 2 reserved, no function
`timescale 1ns/1ps
module rcl_config_loader
  import rcl_pkg::*;
#(
  parameter int CODE_KB = CODE_KB_DEFAULT
)(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // non-volatile configuration array cell
  input  wire logic [7:0]  NV_CFG_BYTE,
  // external programmer read port into the code array
  input  wire logic        PRG_RD,
  input  wire logic [14:0] PRG_ADDR,
  input  wire logic [7:0]  CODE_RD_DATA,
  output logic [14:0]      CODE_RD_ADDR,
  output logic [7:0]       PRG_RD_DATA,
  output logic             PRG_RD_VALID,
  output logic             PRG_RD_REFUSED,
  // applied start-up options
  output logic             CFG_READY,
  output logic             SINGLE_RATE_CLOCKING,
  output logic             OSC_8MHZ,
  output logic             OSC_16MHZ,
  output logic             OSC_32MHZ,
  output logic             OSC_CFG_BAD,
  output logic [1:0]       SECURITY_LEVEL,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA
);
  localparam int CODE_BYTES = CODE_KB * 1024;

  rcl_cfg_if cfg ();

  // load sequencer
  rcl_load_t  state_q;
  rcl_load_t  state_d;
  logic [3:0] settle_q;
  logic [3:0] settle_d;
  logic       settle_end;
  logic       load_done;

  // held configuration byte
  logic [7:0] cfg_byte_q;
  logic [7:0] cfg_byte_d;

  // programmer read answer
  logic       addr_in_range;
  logic       lock_open;
  logic       prg_accept;
  logic       prg_refuse;
  logic       valid_q;
  logic       refused_q;
  logic [7:0] prg_rdata_d;

  // register port
  logic [7:0] status_byte;
  logic [7:0] reg_rdata_d;

  assign settle_end = (settle_q == LOAD_SETTLE_CYCLES - 4'h1);
  assign load_done  = (state_q == RCL_LOAD_DONE);

  // the array output gets a few cycles to settle before it is trusted
  always_comb begin
    state_d  = state_q;
    settle_d = settle_q;
    case (state_q)
      RCL_LOAD_WAIT: begin
        if (settle_end) begin
          state_d = RCL_LOAD_READ;
        end else begin
          settle_d = settle_q + 4'h1;
        end
      end
      RCL_LOAD_READ: begin
        state_d = RCL_LOAD_DONE;
      end
      RCL_LOAD_DONE: begin
        state_d = RCL_LOAD_DONE;
      end
      default: begin
        state_d  = RCL_LOAD_WAIT;
        settle_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= RCL_LOAD_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      settle_q <= 4'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  // one byte, separate from the code array, captured once after reset;
  // reserved bits are dropped so they can never steer anything
  always_comb begin
    cfg_byte_d = cfg_byte_q;
    if (state_q == RCL_LOAD_READ) begin
      cfg_byte_d = NV_CFG_BYTE & CFG_USED_MASK;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_byte_q <= CFG_BYTE_RESET;
    end else begin
      cfg_byte_q <= cfg_byte_d;
    end
  end

  assign cfg.cfg_byte  = cfg_byte_q;
  assign cfg.cfg_valid = load_done;

  rcl_decode u_decode (
    .cfg (cfg)
  );

  assign CFG_READY            = cfg.cfg_valid;
  // no field selects double rate, so single-rate always stands
  assign SINGLE_RATE_CLOCKING = 1'b1;
  assign OSC_8MHZ             = cfg.osc_8mhz;
  assign OSC_16MHZ            = cfg.osc_16mhz;
  // before the load finishes the default (widest) oscillator range runs
  assign OSC_32MHZ            = cfg.osc_32mhz;
  assign OSC_CFG_BAD          = cfg.osc_bad & cfg.cfg_valid;
  assign SECURITY_LEVEL       = cfg.security_level;

  // refused while locked or before the configuration is known, so no
  // byte leaks during start-up; addresses past the array are refused too
  assign addr_in_range = (32'(PRG_ADDR) < CODE_BYTES);
  assign lock_open     = load_done & !cfg.read_protect;
  assign prg_accept    = PRG_RD & lock_open & addr_in_range;
  assign prg_refuse    = PRG_RD & !(lock_open & addr_in_range);

  assign CODE_RD_ADDR = PRG_ADDR;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= prg_accept;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= prg_refuse;
    end
  end

  // a refused read answers zero, never the array byte behind it
  always_comb begin
    prg_rdata_d = 8'h00;
    if (prg_accept) begin
      prg_rdata_d = CODE_RD_DATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PRG_RD_DATA <= 8'h00;
    end else begin
      PRG_RD_DATA <= prg_rdata_d;
    end
  end

  assign PRG_RD_VALID   = valid_q;
  assign PRG_RD_REFUSED = refused_q;

  assign status_byte = {3'h0, OSC_CFG_BAD,
                        cfg.read_protect, SECURITY_LEVEL,
                        CFG_READY};

  // register port: the byte is read-only, so writes are ignored
  always_comb begin
    reg_rdata_d = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        CFG_BYTE_OFFSET: begin
          reg_rdata_d = cfg_byte_q;
        end
        CODE_SIZE_OFFSET: begin
          reg_rdata_d = 8'(CODE_KB);
        end
        STATUS_OFFSET: begin
          reg_rdata_d = status_byte;
        end
        default: begin
          reg_rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= reg_rdata_d;
    end
  end
endmodule

// ===== design/rcl_decode.sv
`timescale 1ns/1ps
module rcl_decode
  import rcl_pkg::*;
(
  // loaded configuration
  rcl_cfg_if.decoder cfg
);
  logic [1:0] osc_sel;
  logic [1:0] lock;

  assign osc_sel = cfg.cfg_byte[OSC_SEL_HI:OSC_SEL_LO];
  assign lock    = cfg.cfg_byte[LOCK_HI:LOCK_LO];

  always_comb begin
    cfg.osc_8mhz  = 1'b0;
    cfg.osc_16mhz = 1'b0;
    cfg.osc_32mhz = 1'b0;
    cfg.osc_bad   = 1'b0;
    case (rcl_osc_t'(osc_sel))
      RCL_OSC_32MHZ: cfg.osc_32mhz = 1'b1;
      RCL_OSC_16MHZ: cfg.osc_16mhz = 1'b1;
      RCL_OSC_8MHZ:  cfg.osc_8mhz  = 1'b1;
      default:       cfg.osc_bad   = 1'b1;
    endcase
  end

  // lock bits read 1 when unprogrammed; an undefined lock code is treated
  // as protected, the safe side for a read-out request
  always_comb begin
    cfg.security_level = 2'h1;
    cfg.read_protect   = 1'b1;
    case (lock)
      2'b11: begin
        cfg.security_level = 2'h1;
        cfg.read_protect   = 1'b0;
      end
      2'b01: begin
        cfg.security_level = 2'h3;
        cfg.read_protect   = 1'b1;
      end
      default: begin
        cfg.security_level = 2'h3;
        cfg.read_protect   = 1'b1;
      end
    endcase
  end
endmodule

// ===== inc/rcl_cfg_if.sv
`timescale 1ns/1ps
interface rcl_cfg_if;
  logic [7:0] cfg_byte;
  logic       cfg_valid;
  logic       osc_8mhz;
  logic       osc_16mhz;
  logic       osc_32mhz;
  logic       osc_bad;
  logic [1:0] security_level;
  logic       read_protect;
  modport loader (output cfg_byte, output cfg_valid,
                  input  osc_8mhz, input osc_16mhz, input osc_32mhz,
                  input  osc_bad, input security_level, input read_protect);
  modport decoder (input cfg_byte, input cfg_valid,
                   output osc_8mhz, output osc_16mhz, output osc_32mhz,
                   output osc_bad, output security_level,
                   output read_protect);
endinterface

// ===== inc/rcl_pkg.sv
package rcl_pkg;
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] CFG_BYTE_OFFSET    = 8'hEF;
  localparam logic [7:0] CODE_SIZE_OFFSET   = 8'hE0;
  localparam logic [7:0] STATUS_OFFSET      = 8'hE1;
  // field positions in the configuration byte
  localparam int         OSC_SEL_HI         = 5;
  localparam int         OSC_SEL_LO         = 4;
  localparam int         LOCK_HI            = 1;
  localparam int         LOCK_LO            = 0;
  localparam logic [7:0] CFG_USED_MASK      = 8'h33;
  // erased byte: lock bits unprogrammed, widest oscillator range
  localparam logic [7:0] CFG_BYTE_RESET     = 8'h33;
  // code array size limits in kilobytes
  localparam int         CODE_KB_MIN        = 16;
  localparam int         CODE_KB_MAX        = 32;
  localparam int         CODE_KB_DEFAULT    = 32;
  // load sequence: cycles to wait for the array to settle
  localparam logic [3:0] LOAD_SETTLE_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    RCL_OSC_FORBIDDEN = 2'b00,
    RCL_OSC_8MHZ      = 2'b01,
    RCL_OSC_16MHZ     = 2'b10,
    RCL_OSC_32MHZ     = 2'b11
  } rcl_osc_t;

  typedef enum logic [1:0] {
    RCL_LOAD_WAIT = 2'b00,
    RCL_LOAD_READ = 2'b01,
    RCL_LOAD_DONE = 2'b10
  } rcl_load_t;
endpackage
